// file: dv/hfd_partner_model.sv
// partner model: byte-wide waveform memory and a snippet player
// assumes the decoder samples read data while mem_rd is high, one pclk
`timescale 1ns/100ps
module hfd_partner_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_rd,
    input wire logic [6:0] mem_addr,
    output logic [7:0] mem_rdata,
    input wire logic snip_start,
    input wire logic pt_done,
    output logic pt_start,
    output logic [2:0] pt_time,
    output logic [3:0] pt_amp,
    output logic snip_done
);
    logic [7:0] mem [0:127];
    logic [7:0] q;
    logic [1:0] phase;
    logic [2:0] cnt;
    // answers while mem_rd is high; outside a read the last byte shows
    // inverted so a mistimed sample cannot match by luck
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~q;
    assign pt_time = 3'h1;
    assign pt_amp = 4'hf;
    always_ff @(posedge pclk)
    begin
        if (mem_rd)
            q <= mem[mem_addr];
    end
    // one point per pass; slow mode stalls the end of each pass
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pt_start <= 1'b0;
            snip_done <= 1'b0;
            phase <= 2'h0;
            cnt <= 3'h0;
        end
        else
        begin
            pt_start <= 1'b0;
            snip_done <= 1'b0;
            if (phase == 2'h0 && snip_start)
            begin
                pt_start <= 1'b1;
                phase <= 2'h1;
            end
            else if (phase == 2'h1 && pt_done)
            begin
                cnt <= slow ? 3'h5 : 3'h0;
                phase <= 2'h2;
            end
            else if (phase == 2'h2 && cnt == 3'h0)
            begin
                snip_done <= 1'b1;
                phase <= 2'h0;
            end
            else if (phase == 2'h2)
                cnt <= cnt - 3'h1;
        end
    end
endmodule : hfd_partner_model

// file: dv/tb_top.sv
// self-checking bench for the frame decoder, APB master and monitors
// assumes the partner model answers memory reads and snippet passes
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top;
    localparam int BASE = 4;
    typedef struct {
        logic [7:0] b1, b2, b3;
        logic fast;
        logic [3:0] idx, amp;
        int pas, len, mult;
        logic [8:0] rate;
        logic [15:0] per;
    } hfd_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, mem_rdata;
    logic [31:0] pwdata, prdata, rdat, dexp;
    logic [6:0] mem_addr;
    logic mem_rd, snip_start, snip_from_first, snip_done, pt_start;
    logic [3:0] snip_index, pt_amp, drive_amp, last_idx, amp_seen;
    logic [2:0] pt_time;
    logic pt_done, silent_active, drive_rate_upd, track_en, slow, rerr;
    logic [8:0] drive_rate;
    int error_cnt, compares, cyc, n_start, n_first, pt_cnt, pt_len;
    int sil_n, e, n_upd;
    hfd_row_t rows[6];
    hfd_row_t r;
    hfd_frame_decoder #(.BASE_CYC(BASE)) dut (.pclk, .presetn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .irq, .mem_addr, .mem_rd, .mem_rdata, .snip_start, .snip_index,
        .snip_from_first, .snip_done, .pt_start, .pt_time, .pt_amp,
        .pt_done, .drive_amp, .silent_active, .drive_rate,
        .drive_rate_upd, .track_en);
    hfd_partner_model u_p (.pclk, .presetn, .slow, .mem_rd, .mem_addr,
        .mem_rdata, .snip_start, .pt_done, .pt_start, .pt_time, .pt_amp,
        .snip_done);
    always #5 pclk = ~pclk;
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wait_st(input logic [31:0] m);
        do
            apb(1'b0, hfd_pkg::OFS_ISTAT, 32'h0);
        while ((rdat & m) !== m);
    endtask : wait_st
    task go(input logic f, input logic [7:0] a);
        apb(1'b1, hfd_pkg::OFS_CTRL, {30'h0, f, 1'b0});
        apb(1'b1, hfd_pkg::OFS_FADDR, {24'h0, a});
        n_start = 0;
        n_first = 0;
        sil_n = 0;
        n_upd = 0;
        apb(1'b1, hfd_pkg::OFS_CTRL, {30'h0, f, 1'b1});
    endtask : go
    task wrap_up;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    always @(posedge pclk)
    begin
        if (pt_start === 1'b1)
            pt_cnt = 0;
        else
            pt_cnt++;
        if (pt_done === 1'b1)
        begin
            pt_len = pt_cnt;
            amp_seen = drive_amp;
        end
        if (silent_active === 1'b1)
            sil_n++;
        if (drive_rate_upd === 1'b1)
            n_upd++;
        if (snip_start === 1'b1)
        begin
            n_start++;
            if (snip_from_first === 1'b1)
                n_first++;
            last_idx = snip_index;
        end
    end
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        rows[0] = '{8'h2b, 8'h00, 8'h00, 0, 4'h3, 4'h7, 1, 1, 16, 0, 0};
        rows[1] = '{8'h55, 8'hb9, 8'h00, 0, 4'hd, 4'h3, 8, 2, 32, 0, 0};
        rows[2] = '{8'h01, 8'h86, 8'hff, 1, 4'h1, 4'hf, 1, 3, 1,
            9'h1ff, 16'h03d2};
        rows[3] = '{8'h7a, 8'h84, 8'h0c, 0, 4'h2, 4'h1, 1, 3, 64,
            9'h00c, 16'h9c40};
        rows[4] = '{8'h0c, 8'h84, 8'h0d, 1, 4'h4, 4'hf, 1, 3, 4,
            9'h00d, 16'h963d};
        rows[5] = '{8'h06, 8'h80, 8'h00, 0, 4'h6, 4'hf, 1, 2, 4,
            9'h00d, 16'h963d};
        for (int i = 0; i < 128; i++)
            u_p.mem[i] = 8'h00;
        for (int i = 0; i < 6; i++)
            {u_p.mem[i*8], u_p.mem[i*8+1], u_p.mem[i*8+2]} =
                {rows[i].b1, rows[i].b2, rows[i].b3};
        u_p.mem[8'h70] = 8'h80;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, hfd_pkg::OFS_IMASK, 32'h0);
        `CHK("imask", 32'h0, rdat)
        apb(1'b0, hfd_pkg::OFS_PER, 32'h0);
        `CHK("per_rst", 32'h0, rdat)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, rerr)
        `CHK("unmapped_data", 32'h0, rdat)
        for (int i = 0; i < 6; i++)
        begin
            r = rows[i];
            slow <= i[0];
            go(r.fast, 8'(i*8));
            wait_st({29'h0, r.b2[7] & r.b2[2], 2'b10});
            apb(1'b1, hfd_pkg::OFS_ISTAT, 32'h7);
            e = 2 * r.mult * BASE;
            `CHK("passes", r.pas, n_start)
            `CHK("repeats", r.pas - 1, n_first)
            `CHK("index", r.idx, last_idx)
            `CHK("amp", r.amp, amp_seen)
            `CHK("pt_len", 1'b1, pt_len >= e && pt_len <= e + 2)
            apb(1'b0, hfd_pkg::OFS_NEXT, 32'h0);
            `CHK("next", 32'(i*8 + r.len), rdat)
            apb(1'b0, hfd_pkg::OFS_RATE, 32'h0);
            `CHK("rate_reg", {23'h0, r.rate}, rdat)
            `CHK("rate", r.rate, drive_rate)
            apb(1'b0, hfd_pkg::OFS_PER, 32'h0);
            `CHK("period", {16'h0, r.per}, rdat)
            `CHK("rate_upd", r.b2[7] & r.b2[2], n_upd)
            dexp = {19'h0, 1'b0, (r.b2[7] ? r.b2[6:3] : 4'h0), r.b1[4:3],
                r.b1[6:5], r.idx};
            apb(1'b0, hfd_pkg::OFS_DEC, 32'h0);
            `CHK("decoded", dexp, rdat)
        end
        go(1'b0, 8'h60);
        wait_st(32'h2);
        `CHK("silent_starts", 0, n_start)
        `CHK("silent_len", 1'b1, sil_n >= 8*BASE && sil_n <= 8*BASE+2)
        `CHK("rate_kept", 9'h00d, drive_rate)
        go(1'b0, 8'h70);
        wait_st(32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, hfd_pkg::OFS_IMASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq_fault", 1'b1, irq)
        apb(1'b1, hfd_pkg::OFS_ISTAT, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK("irq_clear", 1'b0, irq)
        apb(1'b1, hfd_pkg::OFS_CTRL, 32'h6);
        `CHK("track_en", 1'b1, track_en)
        apb(1'b0, hfd_pkg::OFS_CTRL, 32'h0);
        `CHK("ctrl_rd", 32'h6, rdat)
        wrap_up();
    end
endmodule : tb_top

// file: include/hfd_pkg.sv
// shared constants, register map and state codes of the frame decoder
// assumes a 100 MHz pclk and a 7-bit byte address into waveform memory
package hfd_pkg;
    // register byte offsets on the APB slave
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FADDR = 8'h04;
    localparam logic [7:0] OFS_ISTAT = 8'h08;
    localparam logic [7:0] OFS_IMASK = 8'h0c;
    localparam logic [7:0] OFS_DEC = 8'h10;
    localparam logic [7:0] OFS_RATE = 8'h14;
    localparam logic [7:0] OFS_PER = 8'h18;
    localparam logic [7:0] OFS_NEXT = 8'h1c;
    localparam int CTRL_GO = 0;
    localparam int CTRL_FAST = 1;
    localparam int CTRL_TRK = 2;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_RATE = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // frame byte fields
    localparam int KIND_BIT = 7;
    localparam int ATT_LSB = 5;
    localparam int STEP_LSB = 3;
    localparam int REP_LSB = 3;
    localparam int RATE_FLAG_BIT = 2;
    localparam int RATE_MSB_BIT = 1;
    localparam int IDX_HI_BIT = 0;
    // timing
    localparam int CLK_NS = 10;
    localparam int BASE_UNIT_NS = 1360000;
    localparam int BASE_UNIT_CYC = BASE_UNIT_NS / CLK_NS;
    localparam int RATE_STEP_HZ = 2;
    localparam int RATE_MIN_HZ = 25;
    localparam int PERIOD_NUM_US = 1000000;
    localparam logic [3:0] SILENT_UNITS = 4'h2;
    localparam int MEM_AW = 7;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_B1 = 6'h02,
        ST_B2 = 6'h04,
        ST_B3 = 6'h08,
        ST_PLAY = 6'h10,
        ST_WAIT = 6'h20
    } hfd_state_t;

    // time unit as a multiple of the 1.36 ms base unit
    function automatic logic [6:0] unit_mult(input logic fast,
                                             input logic [1:0] sel);
        case ({fast, sel})
            3'b000: unit_mult = 7'h04;
            3'b001: unit_mult = 7'h10;
            3'b010: unit_mult = 7'h20;
            3'b011: unit_mult = 7'h40;
            3'b100: unit_mult = 7'h01;
            3'b101: unit_mult = 7'h04;
            3'b110: unit_mult = 7'h10;
            default: unit_mult = 7'h20;
        endcase
    endfunction : unit_mult
endpackage : hfd_pkg

// file: src/hfd_frame_decoder.sv
// haptic frame decoder: fetches 1-3 byte frame records from waveform
// memory, decodes them and paces snippet playback.
// assumes memory data is valid while mem_rd is high, and that the
// player pulses snip_done at the end of each snippet pass.
`timescale 1ns/100ps
module hfd_frame_decoder #(
    parameter int BASE_CYC = hfd_pkg::BASE_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [6:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    output logic snip_start,
    output logic [3:0] snip_index,
    output logic snip_from_first,
    input wire logic snip_done,
    input wire logic pt_start,
    input wire logic [2:0] pt_time,
    input wire logic [3:0] pt_amp,
    output logic pt_done,
    output logic [3:0] drive_amp,
    output logic silent_active,
    output logic [8:0] drive_rate,
    output logic drive_rate_upd,
    output logic track_en
);
    hfd_pkg::hfd_state_t state;
    logic fast;
    logic [6:0] frame_addr;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [1:0] atten;
    logic [1:0] step;
    logic [2:0] idx_low;
    logic idx_high;
    logic [3:0] rep;
    logic rate_msb;
    logic [3:0] iter;
    logic [3:0] units_left;
    logic [15:0] active_period;
    logic [6:0] next_addr;
    logic tick;
    logic div_done;
    logic [15:0] div_q;

    // bus decode
    wire acc = psel && penable;
    wire wr = acc && pwrite && pready;
    wire sel_ctrl = paddr == hfd_pkg::OFS_CTRL;
    wire sel_faddr = paddr == hfd_pkg::OFS_FADDR;
    wire sel_istat = paddr == hfd_pkg::OFS_ISTAT;
    wire sel_imask = paddr == hfd_pkg::OFS_IMASK;
    wire sel_dec = paddr == hfd_pkg::OFS_DEC;
    wire sel_rate = paddr == hfd_pkg::OFS_RATE;
    wire sel_per = paddr == hfd_pkg::OFS_PER;
    wire sel_next = paddr == hfd_pkg::OFS_NEXT;
    wire hit = sel_ctrl | sel_faddr | sel_istat | sel_imask | sel_dec
             | sel_rate | sel_per | sel_next;
    wire idle = state == hfd_pkg::ST_IDLE;
    wire [31:0] rd_ctrl = {29'h0, track_en, fast, 1'b0};
    wire [31:0] rd_dec = {19'h0, !idle, rep, step, atten, snip_index};
    wire [31:0] rd_mux =
        sel_ctrl ? rd_ctrl :
        sel_faddr ? {25'h0, frame_addr} :
        sel_istat ? {29'h0, irq_stat} :
        sel_imask ? {29'h0, irq_mask} :
        sel_dec ? rd_dec :
        sel_rate ? {23'h0, drive_rate} :
        sel_per ? {16'h0, active_period} :
        sel_next ? {25'h0, next_addr} : 32'h0;
    // a go while a frame is running is dropped, not queued
    wire go = wr && sel_ctrl && pwdata[hfd_pkg::CTRL_GO] && idle;

    // frame byte decode
    wire kind = mem_rdata[hfd_pkg::KIND_BIT];
    wire in_b1 = state == hfd_pkg::ST_B1;
    wire in_b2 = state == hfd_pkg::ST_B2;
    wire in_b3 = state == hfd_pkg::ST_B3;
    wire b1_bad = in_b1 && kind;
    wire b2_ok = in_b2 && kind;
    wire b2_rate = b2_ok && mem_rdata[hfd_pkg::RATE_FLAG_BIT];
    wire silent = snip_index == 4'h0;

    // point timing and iteration end
    wire pt_end = tick && units_left == 4'h1;
    wire pt_load = pt_start && !silent_active;
    wire in_play = state == hfd_pkg::ST_PLAY;
    wire in_wait = state == hfd_pkg::ST_WAIT;
    wire iter_end = in_wait && (silent_active ? pt_end : snip_done);
    wire frame_end = iter_end && iter == rep;

    // sticky events, set wins over a same-cycle clear
    wire [2:0] ev = {div_done, frame_end, b1_bad};
    wire [2:0] w1c = (wr && sel_istat) ? pwdata[2:0] : 3'h0;
    wire [2:0] next_stat = (irq_stat & ~w1c) | ev;

    hfd_unit_timer #(
        .BASE_CYC(BASE_CYC)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(pt_load || (in_play && silent)),
        .fast(fast),
        .sel(step),
        .tick(tick)
    );

    hfd_period_calc u_period (
        .pclk(pclk),
        .presetn(presetn),
        .start(in_b3),
        .rate_word({rate_msb, mem_rdata}),
        .period(div_q),
        .done(div_done)
    );

    // APB slave: one wait state so read data leaves a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= acc && !pready;
            if (acc && !pready)
            begin
                prdata <= pwrite ? 32'h0 : rd_mux;
                pslverr <= !hit;
            end
        end
    end

    // software registers and interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast <= 1'b0;
            track_en <= 1'b0;
            frame_addr <= 7'h0;
            irq_mask <= hfd_pkg::IRQ_MASK_RST;
            irq_stat <= 3'h0;
            irq <= 1'b0;
            active_period <= 16'h0;
        end
        else
        begin
            if (wr && sel_ctrl)
            begin
                fast <= pwdata[hfd_pkg::CTRL_FAST];
                track_en <= pwdata[hfd_pkg::CTRL_TRK];
            end
            if (wr && sel_faddr)
                frame_addr <= pwdata[6:0];
            if (wr && sel_imask)
                irq_mask <= pwdata[2:0];
            irq_stat <= next_stat;
            irq <= |(next_stat & irq_mask);
            if (div_done)
                active_period <= div_q;
        end
    end

    // frame fetch and playback sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= hfd_pkg::ST_IDLE;
            mem_addr <= 7'h0;
            mem_rd <= 1'b0;
            next_addr <= 7'h0;
            atten <= 2'h0;
            step <= 2'h0;
            idx_low <= 3'h0;
            idx_high <= 1'b0;
            rep <= 4'h0;
            rate_msb <= 1'b0;
            iter <= 4'h0;
            snip_start <= 1'b0;
            snip_from_first <= 1'b0;
        end
        else
        begin
            mem_rd <= 1'b0;
            snip_start <= 1'b0;
            case (state)
                hfd_pkg::ST_IDLE:
                begin
                    if (go)
                    begin
                        mem_addr <= frame_addr;
                        mem_rd <= 1'b1;
                        state <= hfd_pkg::ST_B1;
                    end
                end
                hfd_pkg::ST_B1:
                begin
                    if (b1_bad)
                    begin
                        next_addr <= mem_addr;
                        state <= hfd_pkg::ST_IDLE;
                    end
                    else
                    begin
                        atten <= mem_rdata[hfd_pkg::ATT_LSB +: 2];
                        step <= mem_rdata[hfd_pkg::STEP_LSB +: 2];
                        idx_low <= mem_rdata[2:0];
                        mem_addr <= mem_addr + 7'h1;
                        mem_rd <= 1'b1;
                        state <= hfd_pkg::ST_B2;
                    end
                end
                hfd_pkg::ST_B2:
                begin
                    // a kind-zero byte opens the next frame; leave it
                    idx_high <= b2_ok && mem_rdata[hfd_pkg::IDX_HI_BIT];
                    rep <= b2_ok ? mem_rdata[hfd_pkg::REP_LSB +: 4] : 4'h0;
                    rate_msb <= mem_rdata[hfd_pkg::RATE_MSB_BIT];
                    iter <= 4'h0;
                    if (b2_rate)
                    begin
                        mem_addr <= mem_addr + 7'h1;
                        mem_rd <= 1'b1;
                        state <= hfd_pkg::ST_B3;
                    end
                    else
                    begin
                        next_addr <= b2_ok ? mem_addr + 7'h1 : mem_addr;
                        state <= hfd_pkg::ST_PLAY;
                    end
                end
                hfd_pkg::ST_B3:
                begin
                    next_addr <= mem_addr + 7'h1;
                    state <= hfd_pkg::ST_PLAY;
                end
                hfd_pkg::ST_PLAY:
                begin
                    snip_start <= !silent;
                    snip_from_first <= iter != 4'h0;
                    state <= hfd_pkg::ST_WAIT;
                end
                hfd_pkg::ST_WAIT:
                begin
                    if (frame_end)
                        state <= hfd_pkg::ST_IDLE;
                    else if (iter_end)
                    begin
                        iter <= iter + 4'h1;
                        state <= hfd_pkg::ST_PLAY;
                    end
                end
                default: state <= hfd_pkg::ST_IDLE;
            endcase
        end
    end

    assign snip_index = {idx_high, idx_low};

    // drive rate holds across frames; only a rate byte moves it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_rate <= 9'h0;
            drive_rate_upd <= 1'b0;
        end
        else
        begin
            drive_rate_upd <= in_b3;
            if (in_b3)
                drive_rate <= {rate_msb, mem_rdata};
        end
    end

    // point and silence timer; gain applied per point
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            units_left <= 4'h0;
            silent_active <= 1'b0;
            pt_done <= 1'b0;
            drive_amp <= 4'h0;
        end
        else
        begin
            pt_done <= pt_end && !silent_active;
            if (in_play && silent)
            begin
                silent_active <= 1'b1;
                units_left <= hfd_pkg::SILENT_UNITS;
                drive_amp <= 4'h0;
            end
            else if (pt_load)
            begin
                units_left <= {1'b0, pt_time} + 4'h1;
                drive_amp <= pt_amp >> atten;
            end
            else if (tick && units_left != 4'h0)
                units_left <= units_left - 4'h1;
            if (iter_end && silent_active)
                silent_active <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    bad_first_a: assert property (b1_bad |=> irq_stat[0])
        else $error("kind fault not flagged");
    third_gate_a: assert property (in_b2 && !b2_rate |=> !in_b3)
        else $error("third byte read without rate flag");
    no_hi_a: assert property (in_b2 && !kind |=> !idx_high)
        else $error("index high bit set without second byte");
    repeat_n_a: assert property (snip_start |-> iter <= rep)
        else $error("snippet played too often");
    restart_pt_a: assert property (
        snip_start |-> snip_from_first == (iter != 4'h0))
        else $error("repeat start point wrong");
    rate_hold_a: assert property (!in_b3 |=> $stable(drive_rate))
        else $error("drive rate moved without rate byte");
    rate_word_a: assert property (
        in_b3 |=> drive_rate == {$past(rate_msb), $past(mem_rdata)})
        else $error("drive rate word misassembled");
    period_rb_a: assert property (
        div_done |=> active_period == $past(div_q))
        else $error("period readback not updated");
    silence_a: assert property (
        in_play && silent |=> silent_active && units_left == 4'h2)
        else $error("silent snippet length wrong");
    pt_len_a: assert property (
        pt_load && !(in_play && silent)
        |=> units_left == {1'b0, $past(pt_time)} + 4'h1)
        else $error("point length wrong");
    gain_a: assert property (
        pt_load && !(in_play && silent)
        |=> drive_amp == ($past(pt_amp) >> $past(atten)))
        else $error("attenuation wrong");

    fault_c: cover property (b1_bad);
    three_byte_c: cover property (in_b3 ##[1:40] frame_end);
    silent_c: cover property (silent_active ##[1:8] iter_end);
    repeat_c: cover property (snip_start && snip_from_first);
endmodule : hfd_frame_decoder

// file: src/hfd_period_calc.sv
// drive rate word to period in microseconds, serial restoring divider
// assumes start is not repeated within 21 cycles of the previous one
`timescale 1ns/100ps
module hfd_period_calc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [8:0] rate_word,
    output logic [15:0] period,
    output logic done
);
    localparam logic [19:0] NUM = 20'(hfd_pkg::PERIOD_NUM_US);
    localparam logic [9:0] MIN_HZ = 10'(hfd_pkg::RATE_MIN_HZ);
    localparam logic [9:0] STEP = 10'(hfd_pkg::RATE_STEP_HZ);
    logic [19:0] quo;
    logic [10:0] rem;
    logic [9:0] div;
    logic [4:0] cnt;
    wire [9:0] hz = 10'(rate_word * STEP);
    wire [9:0] hz_clamp = hz < MIN_HZ ? MIN_HZ : hz;
    wire [10:0] trial = {rem[9:0], quo[19]};
    wire ge = trial >= {1'b0, div};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quo <= 20'h0;
            rem <= 11'h0;
            div <= 10'h0;
            cnt <= 5'h0;
            period <= 16'h0;
            done <= 1'b0;
        end
        else if (start)
        begin
            quo <= NUM;
            rem <= 11'h0;
            div <= hz_clamp;
            cnt <= 5'h14;
            done <= 1'b0;
        end
        else
        begin
            done <= cnt == 5'h1;
            if (cnt != 5'h0)
            begin
                quo <= {quo[18:0], ge};
                rem <= ge ? trial - {1'b0, div} : trial;
                cnt <= cnt - 5'h1;
                if (cnt == 5'h1)
                    period <= {quo[14:0], ge};
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rate_floor_a: assert property (start |=> div >= MIN_HZ)
        else $error("drive frequency below floor");
endmodule : hfd_period_calc

// file: src/hfd_unit_timer.sv
// snippet time-unit tick generator
// assumes restart is pulsed when a point starts so the first unit is whole
`timescale 1ns/100ps
module hfd_unit_timer #(
    parameter int BASE_CYC = hfd_pkg::BASE_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic fast,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [17:0] pre;
    logic [6:0] mul;
    wire [6:0] lim = hfd_pkg::unit_mult(fast, sel);
    wire pre_end = pre == 18'(BASE_CYC - 1);
    wire mul_end = mul == lim - 7'h01;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre <= 18'h0;
            mul <= 7'h0;
            tick <= 1'b0;
        end
        else if (restart)
        begin
            pre <= 18'h0;
            mul <= 7'h0;
            tick <= 1'b0;
        end
        else
        begin
            pre <= pre_end ? 18'h0 : pre + 18'h1;
            if (pre_end)
                mul <= mul_end ? 7'h0 : mul + 7'h1;
            tick <= pre_end && mul_end;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    unit_tick_a: assert property (tick |-> $past(mul) == $past(lim) - 7'h01)
        else $error("unit tick at wrong multiple");
endmodule : hfd_unit_timer
